// *** tb_transceiver_compliance_id_fields.sv ***
`timescale 1ns/1ns
`include "tcid_regs.svh"
module tb_transceiver_compliance_id_fields import tcid_pkg::*;;
    localparam logic [7:0] OFS [12] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                        8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h24, 8'h3e};
    // Raw values, some with reserved bits set on purpose
    localparam logic [7:0] RAW [12] = '{8'h10, 8'hd0, 8'hc0, 8'h02, 8'h12, 8'h0b,
                                        8'h03, 8'h02, 8'h06, 8'hff, 8'h00, 8'hff};
    localparam logic [7:0] EXP [12] = '{8'h10, 8'hd0, 8'h40, 8'h02, 8'h12, 8'h08,
                                        8'h01, 8'h02, 8'h06, 8'hff, 8'h00, 8'h01};
    // One row per reach variant other than none, then one bad specifier combination: byte 4, byte 5, class field
    localparam logic [7:0] VB4 [8] = '{8'h00, 8'h10, 8'h10, 8'h08, 8'h10, 8'h08, 8'h18, 8'h08};
    localparam logic [7:0] VB5 [8] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h04, 8'h04, 8'h04, 8'h01};
    // Whole class word per row; the last row also leaves the rate unspecified
    localparam logic [31:0] VCLS [8] = '{32'h0000_2005, 32'h0000_2009, 32'h0000_200e,
        32'h0000_2012, 32'h0000_2017, 32'h0000_201b, 32'h0000_201f, 32'h0000_20a1};
    localparam logic [31:0] CLASS_EXP = 32'h0000_2f57;

    logic        CLK;
    logic        RSTN;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        BUSY;
    logic        WR_IGNORED;
    logic [31:0] rd;
    logic        er;
    logic [31:0] vprd [8];
    logic [31:0] vrd [8];
    logic [7:0]  wire_byte;
    int          bad_count;
    int          tests_run;
    int          wig;

    tcid_link_if lk ();
    tcid_dev #(.ETH10G_IB(RAW[0]), .MF_SONET_HI(RAW[1]), .SONET_LO(RAW[2]), .ETH(RAW[3]),
        .FC_DIST_TECH(RAW[4]), .FC_TECH_CABLE(RAW[5]), .FC_MEDIA(RAW[6]), .FC_SPEED(RAW[7]),
        .ENCODING(RAW[8]), .SIG_RATE(RAW[9]), .EXT_COMPL(RAW[10]), .FC_SPEED2(RAW[11]))
        tcid_dev_i (.CLK(CLK), .RSTN(RSTN), .link(lk.dev_end), .BUSY(BUSY),
        .WR_IGNORED(WR_IGNORED));
    tcid_host tcid_host_i (.CLK(CLK), .RSTN(RSTN), .link(lk.host_end), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
    tcid_link_asserts #(.ENC_BYTE(EXP[8])) tcid_link_asserts_i (.CLK(CLK), .RSTN(RSTN),
        .req(lk.req), .wr(lk.wr), .addr(lk.addr), .sdo(lk.sdo), .sdo_valid(lk.sdo_valid),
        .ack(lk.ack), .BUSY(BUSY), .WR_IGNORED(WR_IGNORED));

    // Extra pairs share the APB strobes; only their read data is looked at
    for (genvar g = 0; g < 8; g++) begin : gv
        tcid_link_if vl ();
        tcid_dev #(.MF_SONET_HI(VB4[g]), .SONET_LO(VB5[g]),
            .SIG_RATE((g == 7) ? 8'h00 : 8'h0d)) tcid_dev_i (.CLK(CLK),
            .RSTN(RSTN), .link(vl.dev_end), .BUSY(), .WR_IGNORED());
        tcid_host tcid_host_i (.CLK(CLK), .RSTN(RSTN), .link(vl.host_end), .PSEL(PSEL),
            .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
            .PRDATA(vprd[g]), .PREADY(), .PSLVERR());
    end

    always #50 CLK = ~CLK;

    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %b want %b", $time, msg, got, exp);
        end
    endtask : chk_bit

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (PREADY !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t no ready", $time);
            wrap_up();
        end
        rd = PRDATA;
        er = PSLVERR;
        foreach (vrd[i]) vrd[i] = vprd[i];
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // Polls until idle with the given done bit set
    task automatic wait_status(input int bitn);
        int k;
        k = 0;
        do begin
            apb(1'b0, `TCID_HREG_STATUS, 32'h0);
            k++;
        end while ((rd[0] !== 1'b0 || rd[bitn] !== 1'b1) && k < 100);
        if (rd[bitn] !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t status wait", $time);
            wrap_up();
        end
    endtask : wait_status

    function automatic logic [7:0] exp_of(input logic [7:0] a);
        exp_of = 8'h00;
        for (int i = 0; i < 12; i++) begin
            if (OFS[i] == a) exp_of = EXP[i];
        end
    endfunction : exp_of

    // Wire monitor: rebuilds each byte from the serial line
    always @(posedge CLK) begin
        if (lk.sdo_valid === 1'b1) wire_byte <= {wire_byte[6:0], lk.sdo};
        if (lk.ack === 1'b1 && lk.wr === 1'b0) begin
            chk_word({24'h0, wire_byte}, {24'h0, exp_of(lk.addr)}, "wire byte");
        end
        if (WR_IGNORED === 1'b1) wig++;
    end

    initial begin
        CLK = 1'b0;
        RSTN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        bad_count = 0;
        tests_run = 0;
        wig = 0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        chk_bit(lk.req, 1'b0, "req at reset");
        apb(1'b0, `TCID_HREG_STATUS, 32'h0);
        chk_word(rd, 32'h0, "status at reset");
        apb(1'b0, `TCID_HREG_BYTE0, 32'h0);
        chk_word(rd, 32'h0, "byte at reset");
        apb(1'b1, `TCID_HREG_CTRL, 32'h1);
        wait_status(1);
        for (int r = 0; r < 12; r++) begin
            apb(1'b0, 8'(`TCID_HREG_BYTE0 + 4 * r), 32'h0);
            chk_word(rd, 32'(EXP[r]), "byte");
        end
        apb(1'b0, `TCID_HREG_CLASS, 32'h0);
        chk_word(rd, CLASS_EXP, "class");
        for (int g = 0; g < 8; g++) begin
            chk_word(vrd[g], VCLS[g], "variant");
        end
        apb(1'b1, `TCID_HREG_CTRL, 32'h0055_0c02);
        wait_status(2);
        chk_word(32'(wig), 32'd1, "ignored writes");
        apb(1'b0, `TCID_HREG_CTRL, 32'h0);
        chk_word({24'h0, rd[15:8]}, 32'h0c, "probe addr");
        apb(1'b1, `TCID_HREG_CTRL, 32'h1);
        wait_status(1);
        apb(1'b0, 8'h34, 32'h0);
        chk_word(rd, 32'hff, "rate after probe");
        apb(1'b1, `TCID_HREG_CLASS, 32'h0);
        apb(1'b0, `TCID_HREG_CLASS, 32'h0);
        chk_word(rd, CLASS_EXP, "class after write");
        apb(1'b0, 8'h80, 32'h0);
        chk_bit(er, 1'b1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped data");
        // Reset in the middle of a fetch
        apb(1'b1, `TCID_HREG_CTRL, 32'h1);
        repeat (5) @(posedge CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        chk_bit(lk.req, 1'b0, "req in reset");
        chk_bit(BUSY, 1'b0, "busy in reset");
        RSTN <= 1'b1;
        apb(1'b0, `TCID_HREG_BYTE0, 32'h0);
        chk_word(rd, 32'h0, "byte after reset");
        apb(1'b0, `TCID_HREG_STATUS, 32'h0);
        chk_word(rd, 32'h0, "status after reset");
        wrap_up();
    end
endmodule : tb_transceiver_compliance_id_fields

// *** tcid_dev.sv ***
`timescale 1ns/1ns
`include "tcid_regs.svh"
module tcid_dev
    import tcid_pkg::*;
#(
    parameter logic [7:0] ETH10G_IB      = 8'h00,
    parameter logic [7:0] MF_SONET_HI    = 8'h00,
    parameter logic [7:0] SONET_LO       = 8'h00,
    parameter logic [7:0] ETH            = 8'h01,
    parameter logic [7:0] FC_DIST_TECH   = 8'h00,
    parameter logic [7:0] FC_TECH_CABLE  = 8'h00,
    parameter logic [7:0] FC_MEDIA       = 8'h00,
    parameter logic [7:0] FC_SPEED       = 8'h00,
    parameter logic [7:0] ENCODING       = 8'h01,
    parameter logic [7:0] SIG_RATE       = 8'h0d,
    parameter logic [7:0] EXT_COMPL      = 8'h00,
    parameter logic [7:0] FC_SPEED2      = 8'h00
)(
    input  wire logic CLK,
    input  wire logic RSTN,
    tcid_link_if.dev_end link,
    output logic      BUSY,
    output logic      WR_IGNORED
);
    // Reject contents that break the identification layout
    if ((ETH10G_IB | MF_SONET_HI | SONET_LO | ETH | FC_DIST_TECH | FC_TECH_CABLE
         | FC_MEDIA | FC_SPEED) == 8'h00) begin : g_no_flag
        $error("no compliance flag set");
    end
    if (FC_DIST_TECH[2] && FC_TECH_CABLE[6]) begin : g_sw_clash
        $error("limiting and linear shortwave both set");
    end
    if (MF_SONET_HI[4:3] == 2'b11 && !(MF_SONET_HI[2] | SONET_LO[6] | SONET_LO[2]))
    begin : g_spec_bad
        $error("specifier 11 needs a long reach flag");
    end

    typedef struct packed {
        tcid_dstate_t state;
        logic         ack;
        logic         busy;
        logic         wr_ignored;
    } tcid_dev_st_t;

    tcid_dev_st_t st;
    tcid_dev_st_t next_st;
    logic         sh_load;
    logic [7:0]   sh_din;
    logic         sh_valid;
    logic         sh_last;

    // Fixed contents; reserved bits forced to zero
    function automatic logic [7:0] id_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `TCID_OFS_ETH10G_IB:     v = ETH10G_IB;
            `TCID_OFS_MF_SONET_HI:   v = MF_SONET_HI;
            `TCID_OFS_SONET_LO:      v = SONET_LO & ~`TCID_RSVD_SONET_LO;
            `TCID_OFS_ETH:           v = ETH;
            `TCID_OFS_FC_DIST_TECH:  v = FC_DIST_TECH;
            `TCID_OFS_FC_TECH_CABLE: v = FC_TECH_CABLE & ~`TCID_RSVD_FC_TECH_CABLE;
            `TCID_OFS_FC_MEDIA:      v = FC_MEDIA & ~`TCID_RSVD_FC_MEDIA;
            `TCID_OFS_FC_SPEED:      v = FC_SPEED;
            `TCID_OFS_ENCODING:      v = ENCODING;
            `TCID_OFS_SIG_RATE:      v = SIG_RATE;
            `TCID_OFS_EXT_COMPL:     v = EXT_COMPL;
            `TCID_OFS_FC_SPEED2:     v = FC_SPEED2 & ~`TCID_RSVD_FC_SPEED2;
            default:                 v = 8'h00;
        endcase
        return v;
    endfunction : id_byte

    always_comb begin
        next_st            = st;
        next_st.ack        = 1'b0;
        next_st.wr_ignored = 1'b0;
        sh_load            = 1'b0;
        sh_din             = id_byte(link.addr);
        unique case (st.state)
            TCID_D_IDLE: begin
                if (link.req) begin
                    next_st.busy = 1'b1;
                    if (link.wr) begin
                        // Contents never change on a write
                        next_st.ack        = 1'b1;
                        next_st.wr_ignored = 1'b1;
                        next_st.state      = TCID_D_DRAIN;
                    end else begin
                        sh_load       = 1'b1;
                        next_st.state = TCID_D_SHIFT;
                    end
                end
            end
            TCID_D_SHIFT: begin
                if (sh_last) begin
                    next_st.ack   = 1'b1;
                    next_st.state = TCID_D_DRAIN;
                end
            end
            TCID_D_DRAIN: begin
                // Wait for the host to drop its request
                if (!link.req && !st.ack) begin
                    next_st.busy  = 1'b0;
                    next_st.state = TCID_D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '{state: TCID_D_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    tcid_shifter u_shifter (
        .clk     (CLK),
        .rst_n   (RSTN),
        .load    (sh_load),
        .din     (sh_din),
        .bit_out (link.sdo),
        .valid   (sh_valid),
        .last    (sh_last)
    );

    assign link.sdo_valid = sh_valid;
    assign link.ack       = st.ack;
    assign BUSY           = st.busy;
    assign WR_IGNORED     = st.wr_ignored;
endmodule : tcid_dev

// *** tcid_host.sv ***
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`include "tcid_regs.svh"
module tcid_host
    import tcid_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    tcid_link_if.host_end    link,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    localparam int NB = `TCID_NUM_BYTES;

    typedef struct packed {
        tcid_hstate_t        state;
        logic                req;
        logic                wr;
        logic [7:0]          addr;
        logic [7:0]          wdata;
        logic                fetch;
        logic [3:0]          idx;
        logic [7:0]          shin;
        logic [NB-1:0][7:0]  bytes;
        logic                done;
        logic                wdone;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } tcid_host_st_t;

    tcid_host_st_t st;
    tcid_host_st_t next_st;
    tcid_class_t   cls;
    tcid_variant_t var_code;
    logic [31:0]   class_word;
    logic [31:0]   rdata;
    logic          rerr;
    logic [5:0]    widx;
    logic [3:0]    bidx;
    logic          access;

    function automatic logic [7:0] fetch_addr(input logic [3:0] i);
        logic [7:0] a;
        a = 8'h00;
        case (i)
            4'h0:    a = `TCID_OFS_ETH10G_IB;
            4'h1:    a = `TCID_OFS_MF_SONET_HI;
            4'h2:    a = `TCID_OFS_SONET_LO;
            4'h3:    a = `TCID_OFS_ETH;
            4'h4:    a = `TCID_OFS_FC_DIST_TECH;
            4'h5:    a = `TCID_OFS_FC_TECH_CABLE;
            4'h6:    a = `TCID_OFS_FC_MEDIA;
            4'h7:    a = `TCID_OFS_FC_SPEED;
            4'h8:    a = `TCID_OFS_ENCODING;
            4'h9:    a = `TCID_OFS_SIG_RATE;
            4'ha:    a = `TCID_OFS_EXT_COMPL;
            default: a = `TCID_OFS_FC_SPEED2;
        endcase
        return a;
    endfunction : fetch_addr

    // Reach class from the rate flags of bytes 4 and 5
    always_comb begin
        logic [7:0] b4;
        logic [7:0] b5;
        b4 = st.bytes[1];
        b5 = st.bytes[2];
        if (b4[2] | b5[6] | b5[2]) begin
            cls = TCID_CLS_LONG;
        end else if (b4[1] | b5[5] | b5[1]) begin
            cls = TCID_CLS_INTER;
        end else if (b4[5] | b4[0] | b5[4] | b5[0]) begin
            cls = TCID_CLS_SHORT;
        end else begin
            cls = TCID_CLS_NONE;
        end
        var_code = TCID_VAR_BAD;
        unique case (cls)
            TCID_CLS_NONE:  var_code = TCID_VAR_NONE;
            TCID_CLS_SHORT: begin
                if (b4[4:3] == 2'b00) var_code = TCID_VAR_SR;
                if (b4[4:3] == 2'b10) var_code = TCID_VAR_SR1;
            end
            TCID_CLS_INTER: begin
                if (b4[4:3] == 2'b10) var_code = TCID_VAR_IR1;
                if (b4[4:3] == 2'b01) var_code = TCID_VAR_IR2;
            end
            TCID_CLS_LONG: begin
                if (b4[4:3] == 2'b10) var_code = TCID_VAR_LR1;
                if (b4[4:3] == 2'b01) var_code = TCID_VAR_LR2;
                if (b4[4:3] == 2'b11) var_code = TCID_VAR_LR3;
            end
        endcase
    end

    always_comb begin
        class_word        = 32'h0;
        class_word[1:0]   = cls;
        class_word[5:2]   = var_code;
        class_word[6]     = (st.bytes[9] == `TCID_RATE_EXTENDED);
        class_word[7]     = (st.bytes[9] == `TCID_RATE_UNSPEC);
        class_word[8]     = st.bytes[3][7] | st.bytes[3][6] | st.bytes[3][4]
                            | st.bytes[3][1];
        class_word[9]     = st.bytes[3][1];
        class_word[10]    = st.bytes[5][3] | st.bytes[5][2];
        class_word[11]    = st.bytes[7][1] & st.bytes[11][0];
        class_word[12]    = st.bytes[4][2] & st.bytes[5][6];
        class_word[13]    = (st.bytes[0] | st.bytes[1] | st.bytes[2] | st.bytes[3]
                             | st.bytes[4] | st.bytes[5] | st.bytes[6]
                             | st.bytes[7]) != 8'h00;
    end

    always_comb begin
        widx  = PADDR[7:2] - 6'h04;
        bidx  = widx[3:0];
        rerr  = 1'b0;
        rdata = 32'h0;
        if (PADDR == `TCID_HREG_CTRL) begin
            rdata = {16'h0, st.addr, 7'h0, st.fetch};
        end else if (PADDR == `TCID_HREG_STATUS) begin
            rdata = {29'h0, st.wdone, st.done, (st.state != TCID_H_IDLE)};
        end else if (PADDR == `TCID_HREG_CLASS) begin
            rdata = class_word;
        end else if (PADDR[1:0] == 2'b00 && PADDR >= `TCID_HREG_BYTE0
                     && widx < 6'(NB)) begin
            rdata = {24'h0, st.bytes[bidx]};
        end else begin
            rerr = 1'b1;
        end
    end

    assign access = PSEL && PENABLE && st.pready;

    always_comb begin
        next_st         = st;
        next_st.pready  = PSEL && !PENABLE && !st.pready;
        next_st.pslverr = 1'b0;
        if (PSEL && !PENABLE && !st.pready) begin
            next_st.prdata  = PWRITE ? 32'h0 : rdata;
            next_st.pslverr = rerr;
        end
        unique case (st.state)
            TCID_H_IDLE: begin
                if (access && PWRITE && PADDR == `TCID_HREG_CTRL) begin
                    if (PWDATA[`TCID_CTRL_FETCH]) begin
                        next_st.fetch = 1'b1;
                        next_st.done  = 1'b0;
                        next_st.idx   = 4'h0;
                        next_st.wr    = 1'b0;
                        next_st.addr  = fetch_addr(4'h0);
                        next_st.req   = 1'b1;
                        next_st.state = TCID_H_REQ;
                    end else if (PWDATA[`TCID_CTRL_WPROBE]) begin
                        next_st.fetch = 1'b0;
                        next_st.wdone = 1'b0;
                        next_st.wr    = 1'b1;
                        next_st.addr  = PWDATA[`TCID_CTRL_PADDR_LSB +: 8];
                        next_st.wdata = PWDATA[`TCID_CTRL_PDATA_LSB +: 8];
                        next_st.req   = 1'b1;
                        next_st.state = TCID_H_REQ;
                    end
                end
            end
            TCID_H_REQ: begin
                if (link.sdo_valid) begin
                    next_st.shin = {st.shin[6:0], link.sdo};
                end
                if (link.ack) begin
                    next_st.req = 1'b0;
                    if (st.wr) begin
                        next_st.wdone = 1'b1;
                        next_st.state = TCID_H_IDLE;
                    end else begin
                        next_st.bytes[st.idx] = st.shin;
                        if (st.idx == 4'(NB - 1)) begin
                            next_st.done  = 1'b1;
                            next_st.state = TCID_H_IDLE;
                        end else begin
                            next_st.idx   = st.idx + 4'h1;
                            next_st.state = TCID_H_GAP;
                        end
                    end
                end
            end
            TCID_H_GAP: begin
                next_st.addr  = fetch_addr(st.idx);
                next_st.req   = 1'b1;
                next_st.state = TCID_H_REQ;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '{state: TCID_H_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.req   = st.req;
    assign link.wr    = st.wr;
    assign link.addr  = st.addr;
    assign link.wdata = st.wdata;
    assign PRDATA     = st.prdata;
    assign PREADY     = st.pready;
    assign PSLVERR    = st.pslverr;
endmodule : tcid_host

// *** tcid_link_asserts.sv ***
`timescale 1ns/1ns
`include "tcid_regs.svh"
module tcid_link_asserts
    import tcid_pkg::*;
#(
    parameter logic [7:0] ENC_BYTE = 8'h00
)(
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [7:0] addr,
    input wire logic       sdo,
    input wire logic       sdo_valid,
    input wire logic       ack,
    input wire logic       BUSY,
    input wire logic       WR_IGNORED
);
    logic [7:0] shreg;

    // Byte as seen on the serial line, first bit ends up highest
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            shreg <= 8'h00;
        end else if (sdo_valid) begin
            shreg <= {shreg[6:0], sdo};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_rd_take;
        req && !wr && !BUSY;
    endsequence
    sequence s_shift;
        (sdo_valid && !ack) [*8];
    endsequence
    sequence s_end;
        ack && !sdo_valid;
    endsequence

    AST_READ_FRAME: assert property (s_rd_take |=> s_shift ##1 s_end)
        else $error("read frame shape wrong");
    AST_WRITE_ACK: assert property (
        req && wr && !BUSY |=> ack && WR_IGNORED && !sdo_valid)
        else $error("write not acknowledged as ignored");
    AST_WRIGN_CAUSE: assert property (WR_IGNORED |-> ack && wr && req)
        else $error("ignored-write pulse without write");
    AST_ACK_END: assert property (ack |=> !ack && !req)
        else $error("ack not a single pulse");
    AST_QUIET_IDLE: assert property (!BUSY |-> !sdo_valid && !ack)
        else $error("link activity while idle");
    AST_REQ_HOLD: assert property (
        req && !ack |=> req && $stable(addr) && $stable(wr))
        else $error("request changed before ack");
    AST_ENC_MSB: assert property (
        ack && !wr && addr == `TCID_OFS_ENCODING |-> shreg == ENC_BYTE)
        else $error("encoding byte wrong on wire");
    AST_RSV_SONET: assert property (
        ack && !wr && addr == `TCID_OFS_SONET_LO
        |-> (shreg & `TCID_RSVD_SONET_LO) == 8'h00)
        else $error("reserved sonet bits set");
    AST_RSV_CABLE: assert property (
        ack && !wr && addr == `TCID_OFS_FC_TECH_CABLE
        |-> (shreg & `TCID_RSVD_FC_TECH_CABLE) == 8'h00)
        else $error("reserved cable bits set");
    AST_RSV_MEDIA: assert property (
        ack && !wr && addr == `TCID_OFS_FC_MEDIA
        |-> (shreg & `TCID_RSVD_FC_MEDIA) == 8'h00)
        else $error("reserved media bit set");
    AST_RSV_SPEED2: assert property (
        ack && !wr && addr == `TCID_OFS_FC_SPEED2
        |-> (shreg & `TCID_RSVD_FC_SPEED2) == 8'h00)
        else $error("reserved speed bits set");
endmodule : tcid_link_asserts

// *** tcid_link_if.sv ***
`timescale 1ns/1ns
interface tcid_link_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       sdo;
    logic       sdo_valid;
    logic       ack;

    modport dev_end (
        input  req,
        input  wr,
        input  addr,
        input  wdata,
        output sdo,
        output sdo_valid,
        output ack
    );

    modport host_end (
        output req,
        output wr,
        output addr,
        output wdata,
        input  sdo,
        input  sdo_valid,
        input  ack
    );
endinterface : tcid_link_if

// *** tcid_pkg.sv ***
package tcid_pkg;

    typedef enum logic [1:0] {
        TCID_CLS_NONE,
        TCID_CLS_SHORT,
        TCID_CLS_INTER,
        TCID_CLS_LONG
    } tcid_class_t;

    typedef enum logic [3:0] {
        TCID_VAR_NONE,
        TCID_VAR_SR,
        TCID_VAR_SR1,
        TCID_VAR_IR1,
        TCID_VAR_IR2,
        TCID_VAR_LR1,
        TCID_VAR_LR2,
        TCID_VAR_LR3,
        TCID_VAR_BAD
    } tcid_variant_t;

    typedef enum logic [1:0] {
        TCID_D_IDLE,
        TCID_D_SHIFT,
        TCID_D_DRAIN
    } tcid_dstate_t;

    typedef enum logic [1:0] {
        TCID_H_IDLE,
        TCID_H_REQ,
        TCID_H_GAP
    } tcid_hstate_t;

endpackage : tcid_pkg

// *** tcid_regs.svh ***
`ifndef TCID_REGS_SVH
`define TCID_REGS_SVH

// Module identification byte offsets
`define TCID_OFS_ETH10G_IB      8'h03
`define TCID_OFS_MF_SONET_HI    8'h04
`define TCID_OFS_SONET_LO       8'h05
`define TCID_OFS_ETH            8'h06
`define TCID_OFS_FC_DIST_TECH   8'h07
`define TCID_OFS_FC_TECH_CABLE  8'h08
`define TCID_OFS_FC_MEDIA       8'h09
`define TCID_OFS_FC_SPEED       8'h0a
`define TCID_OFS_ENCODING       8'h0b
`define TCID_OFS_SIG_RATE       8'h0c
`define TCID_OFS_EXT_COMPL      8'h24
`define TCID_OFS_FC_SPEED2      8'h3e

// Bits that must read as zero in each byte
`define TCID_RSVD_SONET_LO      8'h88
`define TCID_RSVD_FC_TECH_CABLE 8'h03
`define TCID_RSVD_FC_MEDIA      8'h02
`define TCID_RSVD_FC_SPEED2     8'hfe

// Signaling-rate special values
`define TCID_RATE_UNSPEC        8'h00
`define TCID_RATE_EXTENDED      8'hff

// Bits per byte and bytes fetched by the host
`define TCID_BYTE_BITS          8
`define TCID_NUM_BYTES          12

// Host register offsets on APB
`define TCID_HREG_CTRL          8'h00
`define TCID_HREG_STATUS        8'h04
`define TCID_HREG_CLASS         8'h08
`define TCID_HREG_BYTE0         8'h10

// Host control register fields
`define TCID_CTRL_FETCH         0
`define TCID_CTRL_WPROBE        1
`define TCID_CTRL_PADDR_LSB     8
`define TCID_CTRL_PDATA_LSB     16

`endif

// *** tcid_shifter.sv ***
`timescale 1ns/1ns
`include "tcid_regs.svh"
module tcid_shifter
    import tcid_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [7:0] din,
    output logic            bit_out,
    output logic            valid,
    output logic            last
);
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] cnt;
        logic       active;
    } tcid_shift_st_t;

    tcid_shift_st_t st;
    tcid_shift_st_t next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.sh     = din;
            next_st.cnt    = 3'h0;
            next_st.active = 1'b1;
        end else if (st.active) begin
            // Most significant bit leaves first
            next_st.sh  = {st.sh[6:0], 1'b0};
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == 3'h7) begin
                next_st.active = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bit_out = st.sh[7];
    assign valid   = st.active;
    assign last    = st.active && (st.cnt == 3'h7);
endmodule : tcid_shifter
